/* logic/dac_event_cfg.svh */
// How it works
// - control bit 3 enables interrupt output and clear-on-read of error flags
// - drift code 00 alarms at 1 or 5, 01 at 2 or 4, 10 at 3, 11 off
// - enable bit 7 passes the acquisition B event to the interrupt
// - enable bit 6 passes the acquisition A event to the interrupt
// - enable bit 5 passes the nonvolatile store download completion to the interrupt
// - enable bit 4 passes the calibration completion to the interrupt
// - enable bit 3 passes the nonvolatile store download error to the interrupt
// - enable bit 2 passes the link sampling monitor error to the interrupt
// - enable bit 1 passes the parity or bit-error-rate failure to the interrupt
// - enable bit 0 passes the data-clock phase monitor error to the interrupt
// - flag bit 7 shows acquisition B ready
// - flag bit 6 shows acquisition A ready
// - flag bit 5 shows the automatic download ready
// - flag bit 4 shows the automatic calibration ready
// - flag bit 3 shows a download error was seen
// - flag bit 2 shows a link sampling monitor error was seen
// - flag bit 1 shows a parity or bit-error-rate error was seen
// - flag bit 0 shows a data-clock phase monitor error was seen
`ifndef DAC_EVENT_CFG_SVH
`define DAC_EVENT_CFG_SVH

// register addresses
`define ADDR_EVENT_CONTROL 5'h0B
`define ADDR_EVENT_ENABLE 5'h0C
`define ADDR_EVENT_FLAGS 5'h0D

// control fields
`define CTRL_GEN_ENABLE_BIT 3
`define CTRL_DRIFT_SEL_LSB 0
`define CTRL_WRITE_MASK 8'h0F

// reset values
`define RESET_EVENT_CONTROL 8'h03
`define RESET_EVENT_ENABLE 8'h00

// drift selector codes and phase values
`define DRIFT_SMALL 2'h0
`define DRIFT_LARGE 2'h1
`define DRIFT_MAX 2'h2
`define DRIFT_OFF 2'h3
`define PHASE_SMALL_LO 3'h1
`define PHASE_SMALL_HI 3'h5
`define PHASE_LARGE_LO 3'h2
`define PHASE_LARGE_HI 3'h4
`define PHASE_MAX 3'h3

// serial frame layout
`define FRAME_INSTR_LAST 4'h7
`define FRAME_LAST 4'hF
`define INSTR_READ_BIT 7

`endif

/* logic/dac_event_pkg.sv */
package dac_event_pkg;

    typedef enum logic [1:0] {
        SER_IDLE,
        SER_INSTR,
        SER_DATA,
        SER_DONE
    } serial_state_type;

    typedef logic [4:0] reg_addr_type;
    typedef logic [7:0] reg_byte_type;

endpackage

/* logic/drift_alarm.sv */
`timescale 1ns/1ps
`include "dac_event_cfg.svh"

module drift_alarm
    import dac_event_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // monitor and selector
    input wire logic [2:0] phase,
    input wire logic [1:0] select,
    // alarm level
    output logic alarm
);

    logic next_alarm;

    always_comb begin
        case (select)
            `DRIFT_SMALL: next_alarm = (phase == `PHASE_SMALL_LO) || (phase == `PHASE_SMALL_HI);
            `DRIFT_LARGE: next_alarm = (phase == `PHASE_LARGE_LO) || (phase == `PHASE_LARGE_HI);
            `DRIFT_MAX: next_alarm = (phase == `PHASE_MAX);
            default: next_alarm = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            alarm <= 1'b0;
        end else begin
            alarm <= next_alarm;
        end
    end

    a_drift_off: assert property (@(posedge clk) disable iff (!rst_b)
        (select == `DRIFT_OFF) |=> !alarm)
        else $error("drift alarm raised while disabled");

    a_drift_small: assert property (@(posedge clk) disable iff (!rst_b)
        (select == `DRIFT_SMALL && (phase == `PHASE_SMALL_LO || phase == `PHASE_SMALL_HI)) |=> alarm)
        else $error("small drift not flagged");

    a_drift_large: assert property (@(posedge clk) disable iff (!rst_b)
        (select == `DRIFT_LARGE) |=> (alarm == ($past(phase) == `PHASE_LARGE_LO || $past(phase) == `PHASE_LARGE_HI)))
        else $error("large drift decode wrong");

    a_drift_max: assert property (@(posedge clk) disable iff (!rst_b)
        (select == `DRIFT_MAX) |=> (alarm == ($past(phase) == `PHASE_MAX)))
        else $error("maximum drift decode wrong");

endmodule

/* logic/sticky_flags.sv */
`timescale 1ns/1ps
`include "dac_event_cfg.svh"

module sticky_flags
    import dac_event_pkg::*;
#(
    parameter int WIDTH = 4
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // event levels and clear pulse
    input wire logic [WIDTH-1:0] eventLevel,
    input wire logic clear,
    // held flags
    output logic [WIDTH-1:0] flag
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_flag
            // set wins over a clear in the same cycle
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    flag[i] <= 1'b0;
                end else begin
                    flag[i] <= eventLevel[i] | (flag[i] & ~clear);
                end
            end

            a_flag_sets: assert property (@(posedge clk) disable iff (!rst_b)
                eventLevel[i] |=> flag[i])
                else $error("error event did not set its flag");

            a_flag_holds: assert property (@(posedge clk) disable iff (!rst_b)
                (flag[i] && !clear) |=> flag[i])
                else $error("error flag lost without clear");
        end
    endgenerate

endmodule

/* logic/dac_event_flag_interrupt_unit.sv */
`timescale 1ns/1ps
`include "dac_event_cfg.svh"

module dac_event_flag_interrupt_unit
    import dac_event_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // serial control port
    input wire logic spiCsB,
    input wire logic spiSclk,
    input wire logic spiSdioIn,
    output logic spiSdioOut,
    output logic spiSdioOe,
    // ready sources
    input wire logic acqBReady,
    input wire logic acqAReady,
    input wire logic autoloadReady,
    input wire logic calibrationReady,
    // error sources
    input wire logic loadError,
    input wire logic linkSamplingError,
    input wire logic parityBerError,
    input wire logic [2:0] phaseMonitor,
    // interrupt
    output logic irq
);

    // two-stage synchronisers for all input pins except clk and rst_b
    localparam int SYNC_W = 13;
    logic [SYNC_W-1:0] syncMeta;
    logic [SYNC_W-1:0] syncOut;
    logic [SYNC_W-1:0] pinBundle;

    assign pinBundle = {spiCsB, spiSclk, spiSdioIn, acqBReady, acqAReady, autoloadReady,
                        calibrationReady, loadError, linkSamplingError, parityBerError, phaseMonitor};

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            syncMeta <= 13'h1000;
            syncOut <= 13'h1000;
        end else begin
            syncMeta <= pinBundle;
            syncOut <= syncMeta;
        end
    end

    logic csBSync;
    logic sclkSync;
    logic sdiSync;
    logic [3:0] readySync;
    logic [2:0] errorSync;
    logic [2:0] phaseSync;

    assign csBSync = syncOut[12];
    assign sclkSync = syncOut[11];
    assign sdiSync = syncOut[10];
    assign readySync = syncOut[9:6];
    assign errorSync = syncOut[5:3];
    assign phaseSync = syncOut[2:0];

    // serial clock edge detection
    logic sclkPrev;
    logic sclkRise;
    logic sclkFall;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sclkPrev <= 1'b0;
        end else begin
            sclkPrev <= sclkSync;
        end
    end

    assign sclkRise = sclkSync & ~sclkPrev;
    assign sclkFall = ~sclkSync & sclkPrev;

    // registers
    reg_byte_type eventControl;
    reg_byte_type eventEnable;
    reg_byte_type eventFlags;
    logic genEnable;
    logic [1:0] driftSelect;

    assign genEnable = eventControl[`CTRL_GEN_ENABLE_BIT];
    assign driftSelect = eventControl[`CTRL_DRIFT_SEL_LSB +: 2];

    // serial frame engine
    serial_state_type state;
    logic [3:0] bitCount;
    logic [7:0] inShift;
    logic [7:0] readShift;
    logic isRead;
    reg_addr_type frameAddr;
    logic wrStrobe;
    reg_addr_type wrAddr;
    reg_byte_type wrData;
    logic flagClear;
    reg_byte_type readValue;

    always_comb begin
        case ({inShift[3:0], sdiSync})
            `ADDR_EVENT_CONTROL: readValue = eventControl;
            `ADDR_EVENT_ENABLE: readValue = eventEnable;
            `ADDR_EVENT_FLAGS: readValue = eventFlags;
            default: readValue = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state <= SER_IDLE;
            bitCount <= 4'h0;
            inShift <= 8'h00;
            isRead <= 1'b0;
            frameAddr <= 5'h00;
        end else if (csBSync) begin
            state <= SER_IDLE;
            bitCount <= 4'h0;
        end else begin
            case (state)
                SER_IDLE: begin
                    state <= SER_INSTR;
                end
                SER_INSTR: begin
                    if (sclkRise) begin
                        inShift <= {inShift[6:0], sdiSync};
                        bitCount <= bitCount + 4'h1;
                        if (bitCount == `FRAME_INSTR_LAST) begin
                            state <= SER_DATA;
                            isRead <= inShift[`INSTR_READ_BIT - 1];
                            frameAddr <= {inShift[3:0], sdiSync};
                        end
                    end
                end
                SER_DATA: begin
                    if (sclkRise) begin
                        inShift <= {inShift[6:0], sdiSync};
                        bitCount <= bitCount + 4'h1;
                        if (bitCount == `FRAME_LAST) begin
                            state <= SER_DONE;
                        end
                    end
                end
                SER_DONE: begin
                    state <= SER_DONE;
                end
                default: begin
                    state <= SER_IDLE;
                end
            endcase
        end
    end

    // write strobe at the last data bit
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wrStrobe <= 1'b0;
            wrAddr <= 5'h00;
            wrData <= 8'h00;
        end else begin
            wrStrobe <= !csBSync && state == SER_DATA && sclkRise && bitCount == `FRAME_LAST && !isRead;
            wrAddr <= frameAddr;
            wrData <= {inShift[6:0], sdiSync};
        end
    end

    // read data shift out on falling serial clock
    logic readLoad;
    assign readLoad = !csBSync && state == SER_INSTR && sclkRise && bitCount == `FRAME_INSTR_LAST
                      && inShift[`INSTR_READ_BIT - 1];

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            readShift <= 8'h00;
            spiSdioOut <= 1'b0;
            spiSdioOe <= 1'b0;
        end else if (csBSync) begin
            spiSdioOe <= 1'b0;
            spiSdioOut <= 1'b0;
        end else if (readLoad) begin
            readShift <= readValue;
        end else if (state == SER_DATA && isRead && sclkFall) begin
            spiSdioOut <= readShift[7];
            spiSdioOe <= 1'b1;
            readShift <= {readShift[6:0], 1'b0};
        end else if (state == SER_DONE && sclkFall) begin
            spiSdioOe <= 1'b0;
        end
    end

    // clear-on-read of error flags, only while enabled
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            flagClear <= 1'b0;
        end else begin
            flagClear <= readLoad && {inShift[3:0], sdiSync} == `ADDR_EVENT_FLAGS && genEnable;
        end
    end

    // writable registers; flag address takes no write
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            eventControl <= `RESET_EVENT_CONTROL;
        end else if (wrStrobe && wrAddr == `ADDR_EVENT_CONTROL) begin
            eventControl <= wrData & `CTRL_WRITE_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            eventEnable <= `RESET_EVENT_ENABLE;
        end else if (wrStrobe && wrAddr == `ADDR_EVENT_ENABLE) begin
            eventEnable <= wrData;
        end
    end

    // event sources
    logic driftAlarm;
    logic [3:0] stickyError;

    drift_alarm u_drift (
        .clk(clk),
        .rst_b(rst_b),
        .phase(phaseSync),
        .select(driftSelect),
        .alarm(driftAlarm)
    );

    sticky_flags #(
        .WIDTH(4)
    ) u_sticky (
        .clk(clk),
        .rst_b(rst_b),
        .eventLevel({errorSync, driftAlarm}),
        .clear(flagClear),
        .flag(stickyError)
    );

    // flag register: live ready levels over held errors
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            eventFlags <= 8'h00;
        end else begin
            eventFlags <= {readySync, stickyError};
        end
    end

    // combined interrupt
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= genEnable && |(eventFlags & eventEnable);
        end
    end

    a_irq_gen_off: assert property (@(posedge clk) disable iff (!rst_b)
        !genEnable |=> !irq)
        else $error("interrupt raised while generation disabled");

    a_irq_combine: assert property (@(posedge clk) disable iff (!rst_b)
        (genEnable && (eventFlags & eventEnable) == 8'h00) |=> !irq)
        else $error("interrupt raised with no enabled flag");

    a_gate_acq_b: assert property (@(posedge clk) disable iff (!rst_b)
        (genEnable && eventFlags[7] && eventEnable[7]) |=> irq)
        else $error("acquisition B event not passed");

    a_gate_acq_a: assert property (@(posedge clk) disable iff (!rst_b)
        (genEnable && eventFlags[6] && eventEnable[6]) |=> irq)
        else $error("acquisition A event not passed");

    a_gate_autoload: assert property (@(posedge clk) disable iff (!rst_b)
        (genEnable && eventFlags[5] && eventEnable[5]) |=> irq)
        else $error("download ready event not passed");

    a_gate_calibration: assert property (@(posedge clk) disable iff (!rst_b)
        (genEnable && eventFlags[4] && eventEnable[4]) |=> irq)
        else $error("calibration event not passed");

    a_gate_load_err: assert property (@(posedge clk) disable iff (!rst_b)
        (genEnable && eventFlags[3] && eventEnable[3]) |=> irq)
        else $error("download error not passed");

    a_gate_link_err: assert property (@(posedge clk) disable iff (!rst_b)
        (genEnable && eventFlags[2] && eventEnable[2]) |=> irq)
        else $error("link sampling error not passed");

    a_gate_parity: assert property (@(posedge clk) disable iff (!rst_b)
        (genEnable && eventFlags[1] && eventEnable[1]) |=> irq)
        else $error("parity error not passed");

    a_gate_drift: assert property (@(posedge clk) disable iff (!rst_b)
        (genEnable && eventFlags[0] && eventEnable[0]) |=> irq)
        else $error("phase monitor error not passed");

    a_ready_follow: assert property (@(posedge clk) disable iff (!rst_b)
        ##1 eventFlags[7:4] == $past(readySync))
        else $error("ready bits do not follow sources");

    a_error_visible: assert property (@(posedge clk) disable iff (!rst_b)
        errorSync[0] |=> ##1 eventFlags[1])
        else $error("parity error not visible in flags");

    a_flags_ro: assert property (@(posedge clk) disable iff (!rst_b)
        (wrStrobe && wrAddr == `ADDR_EVENT_FLAGS) |=> ($stable(eventControl) && $stable(eventEnable) && !flagClear))
        else $error("flag register write had an effect");

    a_no_clear_off: assert property (@(posedge clk) disable iff (!rst_b)
        !genEnable |=> !flagClear)
        else $error("flags cleared while clearance disabled");

endmodule

/* testbench/testbench.sv */
`timescale 1ns/1ps
`include "dac_event_cfg.svh"

module testbench
    import dac_event_pkg::*;
;
    localparam int HALF = 6;

    logic clk;
    logic rst_b;
    logic spiCsB;
    logic spiSclk;
    logic spiSdioIn;
    logic spiSdioOut;
    logic spiSdioOe;
    logic [3:0] readyLevels;
    logic [2:0] errorLevels;
    logic [2:0] phaseMonitor;
    logic irq;
    int failures;
    int cmp_count;
    logic [7:0] oeBits;

    dac_event_flag_interrupt_unit u_dut (
        .clk(clk),
        .rst_b(rst_b),
        .spiCsB(spiCsB),
        .spiSclk(spiSclk),
        .spiSdioIn(spiSdioIn),
        .spiSdioOut(spiSdioOut),
        .spiSdioOe(spiSdioOe),
        .acqBReady(readyLevels[3]),
        .acqAReady(readyLevels[2]),
        .autoloadReady(readyLevels[1]),
        .calibrationReady(readyLevels[0]),
        .loadError(errorLevels[2]),
        .linkSamplingError(errorLevels[1]),
        .parityBerError(errorLevels[0]),
        .phaseMonitor(phaseMonitor),
        .irq(irq)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(string name, logic [7:0] exp, logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wait_clk(int n);
        repeat (n) @(posedge clk);
    endtask

    // one 16-bit frame, msb first, data sampled late in each high phase
    task automatic frame(logic isRead, reg_addr_type addr, reg_byte_type wdata, output reg_byte_type rdata);
        logic [15:0] bits;
        bits = {isRead, 2'b00, addr, wdata};
        rdata = 8'h00;
        @(posedge clk);
        spiCsB <= 1'b0;
        wait_clk(HALF);
        for (int i = 15; i >= 0; i--) begin
            spiSclk <= 1'b0;
            spiSdioIn <= (isRead && i < 8) ? 1'($urandom) : bits[i];
            wait_clk(HALF);
            spiSclk <= 1'b1;
            wait_clk(HALF - 1);
            @(negedge clk);
            if (i < 8) begin
                rdata[i] = spiSdioOut;
                oeBits[i] = spiSdioOe;
            end
            @(posedge clk);
        end
        spiCsB <= 1'b1;
        wait_clk(HALF);
        spiSclk <= 1'b0;
        wait_clk(HALF);
    endtask

    task automatic wr(reg_addr_type addr, reg_byte_type data);
        reg_byte_type dummy;
        frame(1'b0, addr, data, dummy);
    endtask

    task automatic rd_check(string name, reg_addr_type addr, reg_byte_type exp);
        reg_byte_type got;
        frame(1'b1, addr, 8'h00, got);
        check(name, exp, got);
        check("sdio enable idle", 8'h00, {7'h00, spiSdioOe});
        check("sdio enable data", 8'hFF, oeBits);
    endtask

    // ready levels stay, errors and phase are short pulses
    task automatic drive_src(logic [7:0] m);
        @(posedge clk);
        readyLevels <= m[7:4];
        errorLevels <= m[3:1];
        phaseMonitor <= m[0] ? 3'h1 : 3'h0;
        wait_clk(4);
        errorLevels <= 3'b000;
        phaseMonitor <= 3'h0;
        wait_clk(8);
    endtask

    function automatic logic drift_hit(logic [1:0] code, logic [2:0] ph);
        case (code)
            2'h0: return ph == 3'h1 || ph == 3'h5;
            2'h1: return ph == 3'h2 || ph == 3'h4;
            2'h2: return ph == 3'h3;
            default: return 1'b0;
        endcase
    endfunction

    initial begin
        repeat (80000) @(posedge clk);
        failures++;
        $display("[FAIL] watchdog expected finish seen timeout");
        conclude();
    end

    initial begin
        logic [7:0] r;
        logic [7:0] en;
        logic [7:0] m;
        logic gen;
        logic hit;
        failures = 0;
        cmp_count = 0;
        rst_b = 1'b0;
        spiCsB = 1'b1;
        spiSclk = 1'b0;
        spiSdioIn = 1'b0;
        readyLevels = 4'h0;
        errorLevels = 3'h0;
        phaseMonitor = 3'h0;
        void'($urandom(76));
        wait_clk(3);
        rst_b <= 1'b1;
        wait_clk(4);

        check("irq after reset", 8'h00, {7'h00, irq});
        rd_check("control reset", `ADDR_EVENT_CONTROL, 8'h03);
        rd_check("enable reset", `ADDR_EVENT_ENABLE, 8'h00);
        rd_check("flags reset", `ADDR_EVENT_FLAGS, 8'h00);
        $display("test reset done");

        r = 8'($urandom);
        wr(`ADDR_EVENT_ENABLE, r);
        rd_check("enable rw", `ADDR_EVENT_ENABLE, r);
        wr(`ADDR_EVENT_CONTROL, r);
        rd_check("control rw", `ADDR_EVENT_CONTROL, r & 8'h0F);
        wr(`ADDR_EVENT_FLAGS, 8'hFF);
        rd_check("flags write ignored", `ADDR_EVENT_FLAGS, 8'h00);
        rd_check("unmapped read", 5'h1E, 8'h00);
        $display("test registers done");

        wr(`ADDR_EVENT_CONTROL, 8'h08);
        for (int b = 7; b >= 0; b--) begin
            wr(`ADDR_EVENT_ENABLE, 8'(1 << b));
            drive_src(8'(1 << b));
            check("irq passed", 8'h01, {7'h00, irq});
            wr(`ADDR_EVENT_ENABLE, ~8'(1 << b));
            wait_clk(4);
            check("irq blocked", 8'h00, {7'h00, irq});
            rd_check("flag source", `ADDR_EVENT_FLAGS, 8'(1 << b));
            @(posedge clk);
            readyLevels <= 4'h0;
            wait_clk(8);
            rd_check("flag gone", `ADDR_EVENT_FLAGS, 8'h00);
        end
        $display("test sources done");

        wr(`ADDR_EVENT_CONTROL, 8'h00);
        wr(`ADDR_EVENT_ENABLE, 8'hFF);
        drive_src(8'h02);
        check("irq gated off", 8'h00, {7'h00, irq});
        rd_check("flags kept 1", `ADDR_EVENT_FLAGS, 8'h02);
        rd_check("flags kept 2", `ADDR_EVENT_FLAGS, 8'h02);
        wr(`ADDR_EVENT_CONTROL, 8'h08);
        wait_clk(4);
        check("irq gated on", 8'h01, {7'h00, irq});
        rd_check("flags before clear", `ADDR_EVENT_FLAGS, 8'h02);
        rd_check("flags cleared", `ADDR_EVENT_FLAGS, 8'h00);
        check("irq released", 8'h00, {7'h00, irq});
        $display("test gating done");

        wr(`ADDR_EVENT_ENABLE, 8'h01);
        for (int c = 0; c < 4; c++) begin
            wr(`ADDR_EVENT_CONTROL, 8'h08 | 8'(c));
            for (int p = 0; p < 8; p++) begin
                hit = drift_hit(2'(c), 3'(p));
                @(posedge clk);
                phaseMonitor <= 3'(p);
                wait_clk(6);
                phaseMonitor <= 3'h0;
                wait_clk(6);
                check("drift irq", {7'h00, hit}, {7'h00, irq});
                rd_check("drift flag", `ADDR_EVENT_FLAGS, {7'h00, hit});
            end
        end
        $display("test drift done");

        for (int k = 0; k < 20; k++) begin
            en = 8'($urandom);
            m = (k == 0) ? 8'hFF : 8'($urandom);
            gen = (k == 1) ? 1'b0 : 1'($urandom);
            wr(`ADDR_EVENT_CONTROL, {4'h0, gen, 3'b000});
            wr(`ADDR_EVENT_ENABLE, en);
            drive_src(m);
            check("irq random", {7'h00, gen && |(m & en)}, {7'h00, irq});
            rd_check("flags random", `ADDR_EVENT_FLAGS, m);
            @(posedge clk);
            readyLevels <= 4'h0;
            wr(`ADDR_EVENT_CONTROL, 8'h08);
            rd_check("flags after read", `ADDR_EVENT_FLAGS, gen ? 8'h00 : (m & 8'h0F));
        end
        $display("test random done");

        wr(`ADDR_EVENT_ENABLE, 8'h02);
        drive_src(8'h02);
        check("irq before mid reset", 8'h01, {7'h00, irq});
        @(posedge clk);
        rst_b <= 1'b0;
        wait_clk(3);
        rst_b <= 1'b1;
        wait_clk(4);
        check("irq after mid reset", 8'h00, {7'h00, irq});
        rd_check("flags after mid reset", `ADDR_EVENT_FLAGS, 8'h00);
        rd_check("enable after mid reset", `ADDR_EVENT_ENABLE, 8'h00);
        $display("test mid reset done");

        conclude();
    end
endmodule
